// ### bench/mbp_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// master controller on the serial pair
// ********
module mbp_master_model (
  // clock
  input wire logic clk_i,
  // line setup
  input wire logic [15:0] div_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  // serial lines
  output logic line_o,
  input wire logic line_i
);
  logic [7:0] got [$];
  logic [7:0] r;
  // idle mark until a request goes out
  initial line_o = 1'b1;
  // one character; bad flips the parity bit
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, par_en_i ? (^b) ^ par_odd_i ^ bad : 1'b1, b, 1'b0};
    @(negedge clk_i);
    for (int i = 0; i < 10 + par_en_i; i++) begin
      line_o <= f[i];
      repeat (div_i) @(negedge clk_i);
    end
  endtask
  // collect replies, sampled mid-bit
  initial forever begin
    @(negedge line_i);
    repeat (div_i / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (div_i) @(posedge clk_i);
      r[i] = line_i;
    end
    repeat (div_i * (1 + par_en_i)) @(posedge clk_i);
    got.push_back(r);
  end
endmodule
`default_nettype wire

// ### bench/mbp_port_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// port checker
// ********
module mbp_port_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic power_up_i,
  input wire mbp_pkg::mbp_reg_req_t reg_req_i,
  input wire mbp_pkg::mbp_reg_rsp_t reg_rsp_o,
  input wire logic txd_o,
  input wire logic rts_o,
  input wire logic crc_clr_i,
  input wire logic [15:0] rx_crc_o,
  input wire logic [15:0] tx_crc_o,
  input wire logic msg_ok_i,
  input wire logic comm_fault_o,
  input wire logic [7:0] node_address_o,
  input wire logic enter_i,
  input wire logic save_o,
  input wire logic [1:0] run_bits_i,
  input wire logic run_fwd_o,
  input wire logic run_rev_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // answers, address and line
  property p_ack; reg_rsp_o.ack == $past(reg_req_i.valid); endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_hold; !power_up_i |=> $stable(node_address_o); endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_quiet; node_address_o == 8'h00 |-> txd_o; endproperty
  a_quiet: assert property (p_quiet) else $error("silent node sent");
  property p_rts; !txd_o |-> rts_o; endproperty
  a_rts: assert property (p_rts) else $error("rts low in frame");
  // services and supervision
  property p_save; enter_i |=> save_o; endproperty
  a_save: assert property (p_save) else $error("no save");
  property p_stop; run_bits_i == 2'b00 |=> !run_fwd_o && !run_rev_o; endproperty
  a_stop: assert property (p_stop) else $error("run without bits");
  property p_crc; crc_clr_i |=> rx_crc_o == 16'hffff && tx_crc_o == 16'hffff; endproperty
  a_crc: assert property (p_crc) else $error("crc seed");
  property p_ok; msg_ok_i |=> !comm_fault_o; endproperty
  a_ok: assert property (p_ok) else $error("fault after message");
  c_fault: cover property ($rose(comm_fault_o));
  c_tx: cover property ($fell(txd_o));
  c_err: cover property (reg_rsp_o.err);
endmodule
bind mbp_port mbp_port_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .power_up_i(power_up_i), .reg_req_i(reg_req_i),
  .reg_rsp_o(reg_rsp_o), .txd_o(txd_o), .rts_o(rts_o), .crc_clr_i(crc_clr_i),
  .rx_crc_o(rx_crc_o), .tx_crc_o(tx_crc_o), .msg_ok_i(msg_ok_i), .comm_fault_o(comm_fault_o),
  .node_address_o(node_address_o), .enter_i(enter_i), .save_o(save_o),
  .run_bits_i(run_bits_i), .run_fwd_o(run_fwd_o), .run_rev_o(run_rev_o));
`default_nettype wire

// ### bench/tb_mbp_port.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_mbp_port;
  localparam int TK = 40;
  localparam logic [15:0] OFS [11] = '{16'h0425, 16'h0426, 16'h0427, 16'h0428, 16'h0429, 16'h042a,
    16'h042b, 16'h0435, 16'h0436, 16'h043c, 16'h043d};
  localparam logic [15:0] RST [11] = '{16'h001f, 16'h0003, 16'h0000, 16'h0003, 16'h0001, 16'h0005,
    16'h0001, 16'h0014, 16'h0000, 16'h0001, 16'h0000};
  localparam logic [15:0] BAD [11] = '{16'h0021, 16'h0009, 16'h0003, 16'h0004, 16'h0002, 16'h0004,
    16'h0002, 16'h0065, 16'h0002, 16'h0002, 16'h0002};
  logic clk_i, rst_i, power_up_i, crc_clr_i, msg_ok_i, enter_i, tx_valid_i, rxd_i, txd_o, rts_o;
  logic rx_valid_o, rx_err_o, tx_ready_o, comm_fault_o, save_o, run_fwd_o, run_rev_o, par_en, podd, err;
  mbp_pkg::mbp_reg_req_t reg_req_i;
  mbp_pkg::mbp_reg_rsp_t reg_rsp_o;
  logic [7:0] rx_data_o, tx_data_i, node_address_o, b;
  logic [15:0] rx_crc_o, tx_crc_o, vout_ref_i, vmon_o, div, crc, rd;
  logic [15:0] mreg [11];
  logic [1:0] stop_method_o, run_bits_i;
  logic [7:0] q [$];
  int mismatches, compares, seed, n;
  time t_rx;
  mbp_port #(.TICK_CYCLES(TK), .FIFO_DEPTH(32)) DUT (.*);
  mbp_master_model M (.clk_i(clk_i), .div_i(div), .par_en_i(par_en), .par_odd_i(podd),
    .line_o(rxd_i), .line_i(txd_o));
  // ********
  // helpers
  // ********
  function automatic logic [15:0] crcf(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction
  // answer is there one edge after the request
  task automatic rw(input logic we, input logic [15:0] a, input logic [15:0] w);
    reg_req_i = '{1'b1, we, a, w};
    @(negedge clk_i);
    reg_req_i.valid = 1'b0;
    rd = reg_rsp_o.rdata;
    err = reg_rsp_o.err;
    `CHK(reg_rsp_o.ack, 1'b1)
    @(negedge clk_i);
  endtask
  task automatic cfg(input int i, input logic [15:0] v);
    rw(1'b1, OFS[i], v);
    `CHK(err, 1'b0)
    mreg[i] = v;
  endtask
  task automatic chkall;
    for (int i = 0; i < 11; i++) begin
      rw(1'b0, OFS[i], 16'h0000);
      `CHK(rd, mreg[i])
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  // request character; waits for the received pulse alongside
  task automatic rxb(input logic [7:0] d, input logic bad);
    fork
      M.send(d, bad);
      begin
        n = 0;
        while (!rx_valid_o && n < 20000) begin @(negedge clk_i); n++; end
        t_rx = $time;
      end
    join
    `CHK(rx_data_o, d)
    `CHK(rx_err_o, bad)
  endtask
  task automatic finish_test;
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard, well past the expected run
  initial begin
    #2000000;
    mismatches++;
    finish_test;
  end
  // ********
  // scenarios
  // ********
  initial begin
    seed = 32'h5c80;
    {rst_i, power_up_i, crc_clr_i, msg_ok_i, enter_i, tx_valid_i, par_en, podd} = 8'h80;
    reg_req_i = '0;
    {tx_data_i, vout_ref_i, run_bits_i} = '0;
    div = 16'h015b;
    mreg = RST;
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    chkall;
    // out of range writes refused, value kept
    for (int i = 0; i < 11; i++) begin
      rw(1'b1, OFS[i], BAD[i]);
      `CHK(err, 1'b1)
    end
    rw(1'b1, OFS[5], 16'h0042);
    `CHK(err, 1'b1)
    rw(1'b0, 16'h0430, 16'h0000);
    `CHK({err, rd}, 17'h1_0000)
    for (int s = 0; s < 4; s++) begin
      cfg(3, 16'(s));
      @(negedge clk_i);
      `CHK(stop_method_o, 2'(s))
    end
    for (int m = 0; m < 2; m++) begin
      cfg(10, 16'(m));
      for (int v = 0; v < 4; v++) begin
        run_bits_i = 2'(v);
        @(negedge clk_i);
        `CHK({run_fwd_o, run_rev_o}, {v == 1, m == 1 ? v == 3 : v == 2})
      end
    end
    for (int u = 0; u < 2; u++) begin
      cfg(8, 16'(u));
      vout_ref_i = 16'($random(seed));
      @(negedge clk_i);
      `CHK(vmon_o, u == 1 ? vout_ref_i / 16'h000a : vout_ref_i)
    end
    pulse(enter_i);
    `CHK(save_o, 1'b1)
    // silent node: replies dropped at once, buffer never fills
    cfg(0, 16'h0000);
    cfg(5, 16'h0041);
    cfg(1, 16'h0008);
    cfg(2, 16'h0001);
    `CHK(node_address_o, 8'h1f)
    pulse(power_up_i);
    @(negedge clk_i);
    `CHK(node_address_o, 8'h00)
    par_en = 1'b1;
    rxb(8'h5a, 1'b0);
    rxb(8'h3c, 1'b1);
    tx_valid_i = 1'b1;
    n = 0;
    while (tx_ready_o && n < 40) begin
      tx_data_i = 8'($random(seed));
      @(negedge clk_i);
      n++;
    end
    tx_valid_i = 1'b0;
    `CHK(n, 40)
    repeat (75 * TK) @(negedge clk_i);
    `CHK({tx_ready_o, M.got.size() == 0}, 2'b11)
    // addressed request, timed reply, frame checks
    cfg(0, 16'h0002);
    cfg(5, 16'h0005);
    cfg(2, 16'h0002);
    podd = 1'b1;
    pulse(power_up_i);
    pulse(crc_clr_i);
    crc = 16'hffff;
    repeat (2) begin
      b = 8'($random(seed));
      rxb(b, 1'b0);
      crc = crcf(crc, b);
    end
    `CHK(rx_crc_o, crc)
    crc = 16'hffff;
    tx_valid_i = 1'b1;
    repeat (3) begin
      tx_data_i = 8'($random(seed));
      q.push_back(tx_data_i);
      crc = crcf(crc, tx_data_i);
      @(negedge clk_i);
    end
    tx_valid_i = 1'b0;
    n = 0;
    while (txd_o && n < 2000) begin @(negedge clk_i); n++; end
    n = int'(($time - t_rx) / 25);
    `CHK(n >= 5 * TK && n <= 6 * TK, 1'b1)
    n = 0;
    while (M.got.size() < 3 && n < 20000) begin @(negedge clk_i); n++; end
    foreach (q[i]) `CHK(M.got[i], q[i])
    repeat (400) @(negedge clk_i);
    `CHK({rts_o, tx_crc_o}, {1'b0, crc})
    cfg(6, 16'h0000);
    pulse(power_up_i);
    @(negedge clk_i);
    `CHK(rts_o, 1'b1)
    // loss timer with live detect time, enable taken at power-up
    cfg(7, 16'h0001);
    pulse(msg_ok_i);
    repeat (99 * TK) @(negedge clk_i);
    `CHK(comm_fault_o, 1'b0)
    repeat (4 * TK) @(negedge clk_i);
    `CHK(comm_fault_o, 1'b1)
    pulse(msg_ok_i);
    `CHK(comm_fault_o, 1'b0)
    cfg(4, 16'h0000);
    pulse(power_up_i);
    repeat (104 * TK) @(negedge clk_i);
    `CHK(comm_fault_o, 1'b0)
    chkall;
    finish_test;
  end
endmodule
`default_nettype wire

// ### common/mbp_pkg.sv
// What this block does
// R1: address 0..20h, default 1Fh; zero never replies
// R2: new address only after power cycle
// R3: baud codes 0..8 map 1200..115200, default 3
// R4: parity code 0 none, 1 even, 2 odd
// R5: baud and parity taken at power-up only
// R6: comm error reaction from stop-method code
// R7: lost link beyond detect time raises fault
// R8: fault enable taken at power-up only
// R9: reply waits 5..65 ms after request
// R10: wait time taken at power-up only
// R11: request-to-send always on, or only transmitting
// R12: host picks request-to-send mode by wiring; here the request_to_send_control setting picks it
// R13: detect time 0.0..10.0 s, default 2.0 s
// R14: voltage monitor in 0.1 V or 1 V
// R15: enter command stores edited parameter data
// R16: run bits: two buttons, or run plus direction
// R17: master resends after its own timeout
// R18: every slave has a unique nonzero address
// R19: installer power-cycles after setting parameters
// R20: eight data bits, one stop, optional parity
// R21: CRC-16 seeded all ones, both directions
// R22: power-cycled settings copied only at power-up
package mbp_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DETECT_MS_PER_UNIT = 100;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned BAUD_BPS [9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // ****************************************
  // register offsets and indices
  // ****************************************
  localparam logic [15:0] OFS_NODE_ADDRESS = 16'h0425;
  localparam logic [15:0] OFS_BAUD_RATE_SELECT = 16'h0426;
  localparam logic [15:0] OFS_PARITY_SELECT = 16'h0427;
  localparam logic [15:0] OFS_COMM_ERROR_STOP_METHOD = 16'h0428;
  localparam logic [15:0] OFS_COMM_FAULT_ENABLE = 16'h0429;
  localparam logic [15:0] OFS_REPLY_WAIT_TIME = 16'h042A;
  localparam logic [15:0] OFS_REQUEST_TO_SEND_CONTROL = 16'h042B;
  localparam logic [15:0] OFS_COMM_ERROR_DETECT_TIME = 16'h0435;
  localparam logic [15:0] OFS_VOLTAGE_MONITOR_UNITS = 16'h0436;
  localparam logic [15:0] OFS_ENTER_COMMAND_FUNCTION = 16'h043C;
  localparam logic [15:0] OFS_RUN_COMMAND_METHOD = 16'h043D;
  localparam logic [3:0] IDX_NONE = 4'hF;

  // ****************************************
  // limits, codes and reset values
  // ****************************************
  localparam logic [15:0] NODE_ADDRESS_MAX = 16'h0020;
  localparam logic [15:0] BAUD_MAX = 16'h0008;
  localparam logic [15:0] PARITY_MAX = 16'h0002;
  localparam logic [15:0] STOP_METHOD_MAX = 16'h0003;
  localparam logic [15:0] FLAG_MAX = 16'h0001;
  localparam logic [15:0] WAIT_MIN = 16'h0005;
  localparam logic [15:0] WAIT_MAX = 16'h0041;
  localparam logic [15:0] DETECT_MAX = 16'h0064;
  localparam logic [1:0] PARITY_NONE = 2'h0;
  localparam logic [1:0] PARITY_ODD = 2'h2;
  localparam logic RTS_ALWAYS = 1'b0;

  typedef struct packed {
    logic [7:0] node_address;
    logic [3:0] baud_rate_select;
    logic [1:0] parity_select;
    logic [1:0] comm_error_stop_method;
    logic comm_fault_enable;
    logic [6:0] reply_wait_time;
    logic request_to_send_control;
    logic [6:0] comm_error_detect_time;
    logic voltage_monitor_units;
    logic enter_command_function;
    logic run_command_method;
  } mbp_cfg_t;

  localparam mbp_cfg_t CFG_RESET = '{8'h1F, 4'h3, 2'h0, 2'h3, 1'b1, 7'h05, 1'b1, 7'h14, 1'b0, 1'b1, 1'b0};

  // parameter access from the message layer
  typedef struct packed {
    logic valid;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbp_reg_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } mbp_reg_rsp_t;

  // ****************************************
  // decoding helpers
  // ****************************************
  function automatic logic [15:0] baud_div(input logic [3:0] code);
    int unsigned bps;
    bps = ({12'h000, code} <= BAUD_MAX) ? BAUD_BPS[code] : BAUD_BPS[3];
    return 16'((CLK_HZ + bps / 2) / bps);
  endfunction

  function automatic logic [3:0] reg_index(input logic [15:0] addr);
    unique case (addr)
      OFS_NODE_ADDRESS: return 4'h0;
      OFS_BAUD_RATE_SELECT: return 4'h1;
      OFS_PARITY_SELECT: return 4'h2;
      OFS_COMM_ERROR_STOP_METHOD: return 4'h3;
      OFS_COMM_FAULT_ENABLE: return 4'h4;
      OFS_REPLY_WAIT_TIME: return 4'h5;
      OFS_REQUEST_TO_SEND_CONTROL: return 4'h6;
      OFS_COMM_ERROR_DETECT_TIME: return 4'h7;
      OFS_VOLTAGE_MONITOR_UNITS: return 4'h8;
      OFS_ENTER_COMMAND_FUNCTION: return 4'h9;
      OFS_RUN_COMMAND_METHOD: return 4'hA;
      default: return IDX_NONE;
    endcase
  endfunction

  function automatic logic field_ok(input logic [3:0] idx, input logic [15:0] v);
    unique case (idx)
      4'h0: return v <= NODE_ADDRESS_MAX;
      4'h1: return v <= BAUD_MAX;
      4'h2: return v <= PARITY_MAX;
      4'h3: return v <= STOP_METHOD_MAX;
      4'h5: return (v >= WAIT_MIN) && (v <= WAIT_MAX);
      4'h7: return v <= DETECT_MAX;
      4'h4, 4'h6, 4'h8, 4'h9, 4'hA: return v <= FLAG_MAX;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// ### rtl/mbp_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module mbp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic full;
  } mbp_fifo_state_t;

  mbp_fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  // full is held in a flop so the filling side sees no logic path
  always_comb begin
    push = in_valid_i && !q.full;
    pop = out_ready_i && (q.count != '0);
    d = q;
    if (push) d.wptr = (q.wptr == AW'(DEPTH - 1)) ? '0 : q.wptr + 1'b1;
    if (pop) d.rptr = (q.rptr == AW'(DEPTH - 1)) ? '0 : q.rptr + 1'b1;
    d.count = q.count + (AW + 1)'(push) - (AW + 1)'(pop);
    d.full = (d.count == (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage needs no reset, empty pointers hide it
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[q.wptr] <= in_data_i;
    end
  end

  assign in_ready_o = !q.full;
  assign out_valid_o = (q.count != '0);
  assign out_data_o = mem[q.rptr];

endmodule
`default_nettype wire

// ### rtl/mbp_port.sv
`timescale 1ns/100ps
`default_nettype none
module mbp_port #(
  parameter int unsigned TICK_CYCLES = mbp_pkg::TICK_CYCLES,
  parameter int unsigned FIFO_DEPTH = mbp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // power-up strobe from the supply monitor
  input wire logic power_up_i,
  // parameter access
  input wire mbp_pkg::mbp_reg_req_t reg_req_i,
  output mbp_pkg::mbp_reg_rsp_t reg_rsp_o,
  // serial pins
  input wire logic rxd_i,
  output logic txd_o,
  output logic rts_o,
  // received byte stream
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  output logic rx_err_o,
  // reply byte stream
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  // frame check
  input wire logic crc_clr_i,
  output logic [15:0] rx_crc_o,
  output logic [15:0] tx_crc_o,
  // link supervision
  input wire logic msg_ok_i,
  output logic comm_fault_o,
  output logic [1:0] stop_method_o,
  output logic [7:0] node_address_o,
  // drive side services
  input wire logic enter_i,
  output logic save_o,
  input wire logic [15:0] vout_ref_i,
  output logic [15:0] vmon_o,
  input wire logic [1:0] run_bits_i,
  output logic run_fwd_o,
  output logic run_rev_o
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mbp_rx_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} mbp_tx_t;

  typedef struct packed {
    mbp_pkg::mbp_cfg_t stored;
    mbp_pkg::mbp_cfg_t active;
    logic rx_s1;
    logic rx_s2;
    mbp_rx_t rx_st;
    logic [15:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_err;
    mbp_tx_t tx_st;
    logic [15:0] tx_cnt;
    logic [3:0] tx_left;
    logic [10:0] tx_sh;
    logic txd;
    logic rts;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic [15:0] tick_cnt;
    logic [6:0] idle_ms;
    logic [13:0] ce_ms;
    logic fault;
    mbp_pkg::mbp_reg_rsp_t rsp;
    logic [15:0] vmon;
    logic run_fwd;
    logic run_rev;
    logic save;
  } mbp_state_t;

  localparam mbp_state_t ST_RESET = '{
    stored: mbp_pkg::CFG_RESET,
    active: mbp_pkg::CFG_RESET,
    rx_s1: 1'b1,
    rx_s2: 1'b1,
    rx_st: RX_IDLE,
    tx_st: TX_IDLE,
    txd: 1'b1,
    rx_crc: mbp_pkg::CRC_SEED,
    tx_crc: mbp_pkg::CRC_SEED,
    default: '0
  };

  mbp_state_t q, d;
  logic fifo_valid;
  logic fifo_pop;
  logic [7:0] fifo_data;

  // ****************************************
  // reply buffer
  // ****************************************
  // replies queue here so the message layer can run ahead of the wait
  mbp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0] ri;
    logic [15:0] div;
    logic par_en;
    logic [3:0] nbits;
    logic tick;
    logic rx_busy;
    logic tx_par;
    logic [13:0] timeout;
    ri = mbp_pkg::IDX_NONE;
    d = q;
    fifo_pop = 1'b0;
    // line format follows the copy taken at power-up
    div = mbp_pkg::baud_div(q.active.baud_rate_select); // see R3 see R5
    par_en = (q.active.parity_select != mbp_pkg::PARITY_NONE); // see R4
    nbits = par_en ? 4'h9 : 4'h8; // see R20
    rx_busy = (q.rx_st != RX_IDLE);
    tx_par = (^fifo_data) ^ (q.active.parity_select == mbp_pkg::PARITY_ODD);
    timeout = 14'(q.stored.comm_error_detect_time * mbp_pkg::DETECT_MS_PER_UNIT); // see R13

    // millisecond tick, phase restarted by every received character
    tick = (q.tick_cnt == 16'(TICK_CYCLES - 1));
    d.tick_cnt = tick ? '0 : q.tick_cnt + 16'h0001;
    if (tick && (q.idle_ms != '1)) begin
      d.idle_ms = q.idle_ms + 7'h01;
    end

    // parameter access, out-of-range writes refused and value kept
    d.rsp = '0;
    if (reg_req_i.valid) begin
      ri = mbp_pkg::reg_index(reg_req_i.addr);
      d.rsp.ack = 1'b1;
      if (ri == mbp_pkg::IDX_NONE) begin
        d.rsp.err = 1'b1;
      end else if (reg_req_i.we) begin
        if (!mbp_pkg::field_ok(ri, reg_req_i.wdata)) begin
          d.rsp.err = 1'b1; // see R1 see R9 see R13
        end else begin
          unique case (ri)
            4'h0: d.stored.node_address = reg_req_i.wdata[7:0];
            4'h1: d.stored.baud_rate_select = reg_req_i.wdata[3:0];
            4'h2: d.stored.parity_select = reg_req_i.wdata[1:0];
            4'h3: d.stored.comm_error_stop_method = reg_req_i.wdata[1:0];
            4'h4: d.stored.comm_fault_enable = reg_req_i.wdata[0];
            4'h5: d.stored.reply_wait_time = reg_req_i.wdata[6:0];
            4'h6: d.stored.request_to_send_control = reg_req_i.wdata[0];
            4'h7: d.stored.comm_error_detect_time = reg_req_i.wdata[6:0];
            4'h8: d.stored.voltage_monitor_units = reg_req_i.wdata[0];
            4'h9: d.stored.enter_command_function = reg_req_i.wdata[0];
            default: d.stored.run_command_method = reg_req_i.wdata[0];
          endcase
        end
      end else begin
        unique case (ri)
          4'h0: d.rsp.rdata = {8'h00, q.stored.node_address};
          4'h1: d.rsp.rdata = {12'h000, q.stored.baud_rate_select};
          4'h2: d.rsp.rdata = {14'h0000, q.stored.parity_select};
          4'h3: d.rsp.rdata = {14'h0000, q.stored.comm_error_stop_method};
          4'h4: d.rsp.rdata = {15'h0000, q.stored.comm_fault_enable};
          4'h5: d.rsp.rdata = {9'h000, q.stored.reply_wait_time};
          4'h6: d.rsp.rdata = {15'h0000, q.stored.request_to_send_control};
          4'h7: d.rsp.rdata = {9'h000, q.stored.comm_error_detect_time};
          4'h8: d.rsp.rdata = {15'h0000, q.stored.voltage_monitor_units};
          4'h9: d.rsp.rdata = {15'h0000, q.stored.enter_command_function};
          default: d.rsp.rdata = {15'h0000, q.stored.run_command_method};
        endcase
      end
    end

    // power-cycled settings frozen until the next power-up
    if (power_up_i) begin
      d.active = q.stored; // see R2 see R5 see R8 see R10 see R22
    end

    // receiver: two-flop synchroniser, then mid-bit sampling
    d.rx_s1 = rxd_i;
    d.rx_s2 = q.rx_s1;
    d.rx_valid = 1'b0;
    unique case (q.rx_st)
      RX_IDLE: begin
        if (!q.rx_s2) begin
          d.rx_st = RX_START;
          d.rx_cnt = div >> 1;
          d.rx_sh = '0;
        end
      end
      RX_START: begin
        if (q.rx_cnt == '0) begin
          d.rx_st = q.rx_s2 ? RX_IDLE : RX_DATA; // glitch rejected at mid start bit
          d.rx_cnt = div - 16'h0001;
          d.rx_idx = '0;
        end else begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end
      end
      RX_DATA: begin
        if (q.rx_cnt == '0) begin
          d.rx_sh[q.rx_idx] = q.rx_s2;
          d.rx_idx = q.rx_idx + 4'h1;
          d.rx_cnt = div - 16'h0001;
          if (q.rx_idx == nbits - 4'h1) begin
            d.rx_st = RX_STOP; // see R20
          end
        end else begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end
      end
      RX_STOP: begin
        if (q.rx_cnt == '0) begin
          d.rx_st = RX_IDLE;
          d.rx_valid = 1'b1;
          d.rx_data = q.rx_sh[7:0];
          // one stop bit, then parity against the selected sense
          d.rx_err = !q.rx_s2 || (par_en && ((^q.rx_sh) != (q.active.parity_select == mbp_pkg::PARITY_ODD)));
          d.rx_crc = mbp_pkg::crc16_byte(q.rx_crc, q.rx_sh[7:0]); // see R21
        end else begin
          d.rx_cnt = q.rx_cnt - 16'h0001;
        end
      end
    endcase
    if (rx_busy) begin
      d.idle_ms = '0; // wait counts from the end of the last character
      d.tick_cnt = '0;
    end

    // transmitter: start, data lsb first, parity, one stop
    unique case (q.tx_st)
      TX_IDLE: begin
        if (fifo_valid) begin
          if (q.active.node_address == 8'h00) begin
            fifo_pop = 1'b1; // see R1
          end else if (!rx_busy && (q.idle_ms >= q.active.reply_wait_time)) begin
            fifo_pop = 1'b1; // see R9
            d.tx_st = TX_SHIFT;
            d.tx_cnt = div - 16'h0001;
            d.tx_sh = par_en ? {1'b1, tx_par, fifo_data, 1'b0} : {2'b11, fifo_data, 1'b0}; // see R20
            d.tx_left = nbits + 4'h2;
            d.txd = 1'b0;
            d.tx_crc = mbp_pkg::crc16_byte(q.tx_crc, fifo_data); // see R21
          end
        end
      end
      TX_SHIFT: begin
        if (q.tx_cnt != '0) begin
          d.tx_cnt = q.tx_cnt - 16'h0001;
        end else if (q.tx_left == 4'h1) begin
          d.tx_st = TX_IDLE;
          d.txd = 1'b1;
        end else begin
          d.tx_sh = q.tx_sh >> 1;
          d.txd = q.tx_sh[1];
          d.tx_left = q.tx_left - 4'h1;
          d.tx_cnt = div - 16'h0001;
        end
      end
    endcase
    if (crc_clr_i) begin
      d.rx_crc = mbp_pkg::CRC_SEED; // see R21
      d.tx_crc = mbp_pkg::CRC_SEED;
    end

    // line driver enable follows the transmitter unless held on
    d.rts = (q.active.request_to_send_control == mbp_pkg::RTS_ALWAYS) || (d.tx_st == TX_SHIFT); // see R11

    // loss of link: a good message restarts the timer and heals the fault
    if (msg_ok_i) begin
      d.ce_ms = '0;
      d.fault = 1'b0;
    end else begin
      if (tick && (q.ce_ms != '1)) begin
        d.ce_ms = q.ce_ms + 14'h0001;
      end
      if (q.active.comm_fault_enable && (q.ce_ms > timeout)) begin
        d.fault = 1'b1; // see R7 see R8
      end
    end

    // monitor scaling; the divider is slow logic but has a full cycle
    d.vmon = q.stored.voltage_monitor_units ? vout_ref_i / 16'h000A : vout_ref_i; // see R14

    // both enter variants store edited data on the command
    d.save = enter_i; // see R15

    // run command decode, both bits set means stop in two-button mode
    if (q.stored.run_command_method) begin
      d.run_fwd = run_bits_i[0] && !run_bits_i[1]; // see R16
      d.run_rev = run_bits_i[0] && run_bits_i[1];
    end else begin
      d.run_fwd = run_bits_i[0] && !run_bits_i[1]; // see R16
      d.run_rev = run_bits_i[1] && !run_bits_i[0];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign reg_rsp_o = q.rsp;
  assign txd_o = q.txd;
  assign rts_o = q.rts;
  assign rx_data_o = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  assign rx_err_o = q.rx_err;
  assign rx_crc_o = q.rx_crc;
  assign tx_crc_o = q.tx_crc;
  assign comm_fault_o = q.fault;
  assign stop_method_o = q.stored.comm_error_stop_method; // see R6
  assign node_address_o = q.active.node_address;
  assign save_o = q.save;
  assign vmon_o = q.vmon;
  assign run_fwd_o = q.run_fwd;
  assign run_rev_o = q.run_rev;

endmodule
`default_nettype wire
